/* core/emt_resolver.sv */
// effective memory type resolver with apb control and status registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module emt_resolver (
	input  wire logic        CLK_SYS_I,     // system clock, 50 MHz
	input  wire logic        RST_I,         // synchronous reset, active high
	// apb slave
	input  wire logic        PSEL_I,        // apb select
	input  wire logic        PENABLE_I,     // apb access phase
	input  wire logic        PWRITE_I,      // apb direction, 1 = write
	input  wire logic [11:0] PADDR_I,       // apb byte address
	input  wire logic [31:0] PWDATA_I,      // apb write data
	input  wire logic [3:0]  PSTRB_I,       // apb byte strobes
	output logic      [31:0] PRDATA_O,      // apb read data
	output logic             PREADY_O,      // apb ready
	output logic             PSLVERR_O,     // apb error
	// request from page translation
	input  wire logic        REQ_VALID_I,   // resolve request
	input  wire logic [2:0]  REQ_RANGE_I,   // range_memory_type_regs type
	input  wire logic        REQ_PCD_I,     // page_cache_disable
	input  wire logic        REQ_PWT_I,     // page_write_through
	input  wire logic        REQ_PAT_I,     // page_attribute_table bit
	input  wire logic        REQ_WRITE_I,   // access is a write
	input  wire logic        REQ_CONT_I,    // second page of a crossing access
	// result to cache and bus controllers
	output logic             RES_VALID_O,   // result pulse
	output logic      [2:0]  RES_TYPE_O,    // effective memory type
	output logic             RES_CHECK_O,   // caches must be looked up
	output logic             RES_FILL_O,    // line fill allowed
	output logic             RES_STRICT_O,  // strict ordering required
	output logic             RES_SPLIT_O,   // write goes out once per page
	// global mode and sequence events
	output logic             NO_FILL_O,     // global cache-disable active
	output logic             NO_WB_O,       // global no-writeback active
	output logic             RANGE_OFF_O,   // range registers disabled
	input  wire logic        FLUSH_DONE_I   // flush_invalidate_all_op finished, pulse
);

	// ==========================================================================
	// registers
	logic [31:0]                     ctrl_q;
	logic [31:0]                     attr_q;
	logic [emt_pkg::SPLIT_CNT_W-1:0] split_cnt_q;
	logic [3:0]                      seq_q;
	logic [31:0]                     prdata_q;
	logic                            pslverr_q;
	logic                            res_valid_q;
	logic [2:0]                      res_type_q;
	logic                            res_check_q;
	logic                            res_fill_q;
	logic                            res_strict_q;
	logic                            res_split_q;
	logic [2:0]                      last_type_q;

	// ==========================================================================
	// control fields
	logic paging_en;
	logic attr_en;
	logic range_off;
	logic no_wb;
	logic cache_dis;
	logic normal_mode;

	assign paging_en   = ctrl_q[emt_pkg::CTRL_PAGING_BIT];
	assign attr_en     = ctrl_q[emt_pkg::CTRL_ATTR_EN_BIT];
	assign range_off   = ctrl_q[emt_pkg::CTRL_RANGE_OFF_BIT];
	assign no_wb       = ctrl_q[emt_pkg::CTRL_NO_WRITEBACK_BIT];
	assign cache_dis   = ctrl_q[emt_pkg::CTRL_CACHE_DISABLE_BIT];
	assign normal_mode = !cache_dis && !no_wb;

	// ==========================================================================
	// apb decode
	logic apb_setup;
	logic apb_wr;
	logic hit_ctrl;
	logic hit_attr;
	logic hit_status;
	logic hit_split;
	logic hit_any;
	logic wr_ctrl;
	logic wr_attr;
	logic wr_split;

	assign apb_setup  = PSEL_I && !PENABLE_I;
	// zero wait states: the access phase always completes on its first edge
	assign apb_wr     = PSEL_I && PENABLE_I && PWRITE_I;
	assign hit_ctrl   = (PADDR_I == emt_pkg::ADDR_CTRL);
	assign hit_attr   = (PADDR_I == emt_pkg::ADDR_ATTR);
	assign hit_status = (PADDR_I == emt_pkg::ADDR_STATUS);
	assign hit_split  = (PADDR_I == emt_pkg::ADDR_SPLIT);
	assign hit_any    = hit_ctrl || hit_attr || hit_status || hit_split;
	assign wr_ctrl    = apb_wr && hit_ctrl;
	assign wr_attr    = apb_wr && hit_attr;
	assign wr_split   = apb_wr && hit_split;

	// ==========================================================================
	// resolve path
	logic [2:0] range_clean;
	logic [2:0] range_eff;
	logic [2:0] entry_idx;
	logic [2:0] entry_type;
	logic [2:0] legacy_type;
	logic       legacy_page;
	logic [2:0] table_type;
	logic       table_page;
	logic       page_rules;
	logic       use_table;
	logic [2:0] res_type_d;
	logic       res_from_page;
	logic       res_check_d;
	logic       res_fill_d;
	logic       res_strict_d;
	logic       res_split_d;

	// range registers turned off behave as uncacheable everywhere
	assign range_clean = emt_pkg::mt_range_clean(REQ_RANGE_I);
	assign range_eff   = range_off ? emt_pkg::MT_UNCACHEABLE : range_clean;
	assign entry_idx   = {REQ_PAT_I, REQ_PCD_I, REQ_PWT_I};
	assign entry_type  = emt_pkg::mt_entry_clean(attr_q[entry_idx*emt_pkg::ATTR_ENTRY_W +: 3]);
	assign page_rules  = normal_mode && paging_en;
	assign use_table   = attr_en && REQ_PAT_I;

	emt_legacy_map u_legacy (
		.range_i     (range_eff),
		.pcd_i       (REQ_PCD_I),
		.pwt_i       (REQ_PWT_I),
		.eff_o       (legacy_type),
		.from_page_o (legacy_page)
	);

	emt_table_map u_table (
		.range_i     (range_eff),
		.entry_i     (entry_type),
		.eff_o       (table_type),
		.from_page_o (table_page)
	);

	always_comb begin
		res_type_d    = range_eff;
		res_from_page = 1'b0;
		if (page_rules) begin
			if (use_table) begin
				res_type_d    = table_type;
				res_from_page = table_page;
			end else begin
				res_type_d    = legacy_type;
				res_from_page = legacy_page;
			end
		end
	end

	// an uncacheable result from the range side skips the cache lookup;
	// cache-disable alone keeps lookups going so read hits are still served
	assign res_check_d  = (res_type_d != emt_pkg::MT_UNCACHEABLE) || res_from_page;
	assign res_fill_d   = emt_pkg::mt_fills(res_type_d) && !cache_dis;
	// strict ordering follows only from the type, never from cache-disable
	assign res_strict_d = (res_type_d == emt_pkg::MT_UNCACHEABLE);
	// second half of a crossing write lands on a page of another type
	assign res_split_d  = REQ_CONT_I && REQ_WRITE_I && (res_type_d != last_type_q);

	// ==========================================================================
	// result registers
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			res_valid_q <= 1'b0;
		end else begin
			res_valid_q <= REQ_VALID_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			res_type_q   <= emt_pkg::MT_UNCACHEABLE;
			res_check_q  <= 1'b0;
			res_fill_q   <= 1'b0;
			res_strict_q <= 1'b0;
			res_split_q  <= 1'b0;
			last_type_q  <= emt_pkg::MT_UNCACHEABLE;
		end else if (REQ_VALID_I) begin
			res_type_q   <= res_type_d;
			res_check_q  <= res_check_d;
			res_fill_q   <= res_fill_d;
			res_strict_q <= res_strict_d;
			res_split_q  <= res_split_d;
			last_type_q  <= res_type_d;
		end else begin
			res_split_q  <= 1'b0;
		end
	end

	// ==========================================================================
	// control and attribute registers
	logic [31:0] ctrl_next;

	assign ctrl_next = emt_pkg::apply_strobe(ctrl_q, PWDATA_I, PSTRB_I, emt_pkg::CTRL_MASK);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ctrl_q <= emt_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_next;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			attr_q <= emt_pkg::ATTR_RESET;
		end else if (wr_attr) begin
			attr_q <= emt_pkg::apply_strobe(attr_q, PWDATA_I, PSTRB_I, emt_pkg::ATTR_MASK);
		end
	end

	// ==========================================================================
	// split write counter, saturating; a clear in the same cycle as a count restarts it at one
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			split_cnt_q <= '0;
		end else if (REQ_VALID_I && res_split_d) begin
			if (wr_split)
				split_cnt_q <= {{(emt_pkg::SPLIT_CNT_W-1){1'b0}}, 1'b1};
			else if (split_cnt_q != {emt_pkg::SPLIT_CNT_W{1'b1}})
				split_cnt_q <= split_cnt_q + 1'b1;
		end else if (wr_split) begin
			split_cnt_q <= '0;
		end
	end

	// ==========================================================================
	// disable sequence tracker
	// seq bit 0: no-fill mode entered, bit 1: first flush, bit 2: range off, bit 3: second flush
	// progress is only observed, software ordering is not enforced
	logic cd_next;
	logic nw_next;
	logic ro_next;
	logic [3:0] seq_d;

	assign cd_next = wr_ctrl ? ctrl_next[emt_pkg::CTRL_CACHE_DISABLE_BIT] : cache_dis;
	assign nw_next = wr_ctrl ? ctrl_next[emt_pkg::CTRL_NO_WRITEBACK_BIT] : no_wb;
	assign ro_next = wr_ctrl ? ctrl_next[emt_pkg::CTRL_RANGE_OFF_BIT] : range_off;

	always_comb begin
		seq_d = seq_q;
		if (!cd_next)
			seq_d = 4'h0;
		if (cd_next && !nw_next)
			seq_d[0] = 1'b1;
		if (FLUSH_DONE_I && seq_q[0])
			seq_d[1] = 1'b1;
		if (ro_next && seq_q[1])
			seq_d[2] = 1'b1;
		if (FLUSH_DONE_I && seq_q[2])
			seq_d[3] = 1'b1;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			seq_q <= 4'h0;
		end else begin
			seq_q <= seq_d;
		end
	end

	// ==========================================================================
	// apb read data, captured in the setup cycle
	logic [31:0] status_word;
	logic [31:0] rd_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[emt_pkg::STAT_TYPE_LSB +: 3]  = last_type_q;
		status_word[emt_pkg::STAT_CHECK_BIT]      = res_check_q;
		status_word[emt_pkg::STAT_FILL_BIT]       = res_fill_q;
		status_word[emt_pkg::STAT_STRICT_BIT]     = res_strict_q;
		status_word[emt_pkg::STAT_SEQ_LSB +: 4]   = seq_q;
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_ctrl)
			rd_word = ctrl_q;
		else if (hit_attr)
			rd_word = attr_q;
		else if (hit_status)
			rd_word = status_word;
		else if (hit_split)
			rd_word = {{(32-emt_pkg::SPLIT_CNT_W){1'b0}}, split_cnt_q};
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			prdata_q <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_word;
		end
	end

	// unmapped addresses and writes to the status word answer with an error
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pslverr_q <= 1'b0;
		end else if (apb_setup) begin
			pslverr_q <= !hit_any || (PWRITE_I && hit_status);
		end
	end

	// ==========================================================================
	// outputs
	assign PRDATA_O     = prdata_q;
	assign PREADY_O     = 1'b1;
	assign PSLVERR_O    = pslverr_q && PSEL_I && PENABLE_I;
	assign RES_VALID_O  = res_valid_q;
	assign RES_TYPE_O   = res_type_q;
	assign RES_CHECK_O  = res_check_q;
	assign RES_FILL_O   = res_fill_q;
	assign RES_STRICT_O = res_strict_q;
	assign RES_SPLIT_O  = res_split_q;
	assign NO_FILL_O    = cache_dis;
	assign NO_WB_O      = no_wb;
	assign RANGE_OFF_O  = range_off;

endmodule : emt_resolver

/* core/emt_pkg.sv */
// constants, memory type codes and helper functions for the effective memory type resolver
// Functional notes
// - page-level combining only while global cache-disable and no-writeback are both clear
// - legacy mode, both page bits 0: range type passes unchanged
// - legacy mode, page cache-disable set gives uncacheable, except two special cases
// - legacy, write-through bit alone: write-back becomes write-through, others unchanged
// - legacy, cache-disable alone on write-combining or write-protected gives write-combining
// - pages with attribute-table bit 0 always use the legacy mapping
// - table entry picked by attribute, cache-disable, write-through bits; write-back takes entry
// - uncacheable range gives uncacheable unless entry is write-combining; no cache check
// - write-combining range: strong UC, WT, WP give UC; weak UC, WC, WB give WC
// - write-through range: UC kinds UC, WC stays, WT or WB give WT, WP gives WP
// - write-protected range: UC gives UC; weak UC, WC give WC; WT gives WT; WB, WP give WP
// - uncacheable coming from page level still requires a cache check
// - a write crossing pages of different types may be issued twice; flag it
// - with cache-disable set and caches unflushed, read hits still served
// - cache-disable alone forces neither uncacheable nor strict ordering
// - no-writeback is control bit 29 and with cache-disable sets the global mode
// - page cache attributes act only with paging on and cache-disable clear
package emt_pkg;

	// ==========================================================================
	// memory type codes
	localparam logic [2:0] MT_UNCACHEABLE      = 3'h0;
	localparam logic [2:0] MT_WRITE_COMBINING  = 3'h1;
	localparam logic [2:0] MT_WRITE_THROUGH    = 3'h4;
	localparam logic [2:0] MT_WRITE_PROTECTED  = 3'h5;
	localparam logic [2:0] MT_WRITE_BACK       = 3'h6;
	localparam logic [2:0] MT_WEAK_UNCACHEABLE = 3'h7;

	// ==========================================================================
	// register map (byte addresses)
	localparam int         ADDR_W      = 12;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_ATTR   = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_SPLIT  = 12'h00c;

	// ==========================================================================
	// control fields and reset values
	localparam int CTRL_PAGING_BIT        = 0;
	localparam int CTRL_ATTR_EN_BIT       = 1;
	localparam int CTRL_RANGE_OFF_BIT     = 2;
	localparam int CTRL_NO_WRITEBACK_BIT  = 29;
	localparam int CTRL_CACHE_DISABLE_BIT = 30;
	localparam logic [31:0] CTRL_MASK     = 32'h6000_0007;
	localparam logic [31:0] CTRL_RESET    = 32'h6000_0000;

	localparam int          ATTR_ENTRY_W = 3;
	localparam int          ATTR_ENTRIES = 8;
	localparam logic [31:0] ATTR_MASK    = 32'h00ff_ffff;
	localparam logic [31:0] ATTR_RESET   = 32'h001e_61e6;

	// ==========================================================================
	// status fields
	localparam int STAT_TYPE_LSB   = 0;
	localparam int STAT_CHECK_BIT  = 3;
	localparam int STAT_FILL_BIT   = 4;
	localparam int STAT_STRICT_BIT = 5;
	localparam int STAT_SEQ_LSB    = 8;
	localparam int SPLIT_CNT_W     = 16;

	// ==========================================================================
	// helpers
	function automatic logic mt_fills(input logic [2:0] t);
		return (t == MT_WRITE_THROUGH) || (t == MT_WRITE_PROTECTED) || (t == MT_WRITE_BACK);
	endfunction : mt_fills

	function automatic logic [2:0] mt_range_clean(input logic [2:0] t);
		// range registers never hold weak uncacheable; anything odd reads as uncacheable
		if ((t == MT_WRITE_COMBINING) || mt_fills(t))
			return t;
		return MT_UNCACHEABLE;
	endfunction : mt_range_clean

	function automatic logic [2:0] mt_entry_clean(input logic [2:0] t);
		if ((t == MT_WRITE_COMBINING) || (t == MT_WEAK_UNCACHEABLE) || mt_fills(t))
			return t;
		return MT_UNCACHEABLE;
	endfunction : mt_entry_clean

	function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r & mask;
	endfunction : apply_strobe

endpackage : emt_pkg

/* core/emt_legacy_map.sv */
// legacy mapping of range type and page cache bits to an effective type
`timescale 1ns/1ps
module emt_legacy_map (
	input  wire logic [2:0] range_i,      // cleaned range type
	input  wire logic       pcd_i,        // page_cache_disable
	input  wire logic       pwt_i,        // page_write_through
	output logic      [2:0] eff_o,        // effective type
	output logic            from_page_o   // uncacheable caused by page bits
);

	// ==========================================================================
	// mapping
	always_comb begin
		eff_o       = range_i;
		from_page_o = 1'b0;
		if (!pcd_i && !pwt_i) begin
			eff_o = range_i;
		end else if (pcd_i) begin
			if (!pwt_i && ((range_i == emt_pkg::MT_WRITE_COMBINING) ||
				(range_i == emt_pkg::MT_WRITE_PROTECTED))) begin
				eff_o = emt_pkg::MT_WRITE_COMBINING;
			end else begin
				eff_o       = emt_pkg::MT_UNCACHEABLE;
				from_page_o = (range_i != emt_pkg::MT_UNCACHEABLE);
			end
		end else begin
			eff_o = (range_i == emt_pkg::MT_WRITE_BACK) ? emt_pkg::MT_WRITE_THROUGH : range_i;
		end
	end

endmodule : emt_legacy_map

/* core/emt_table_map.sv */
// attribute-table mapping of range type and selected entry type to an effective type
`timescale 1ns/1ps
module emt_table_map (
	input  wire logic [2:0] range_i,      // cleaned range type
	input  wire logic [2:0] entry_i,      // cleaned table entry type
	output logic      [2:0] eff_o,        // effective type
	output logic            from_page_o   // uncacheable caused by the entry
);

	// ==========================================================================
	// mapping
	always_comb begin
		eff_o       = emt_pkg::MT_UNCACHEABLE;
		from_page_o = 1'b0;
		unique case (range_i)
			emt_pkg::MT_UNCACHEABLE: begin
				// an uncacheable result is never cached, so no cache check; a write-combining result is still checked
				eff_o = (entry_i == emt_pkg::MT_WRITE_COMBINING) ?
					emt_pkg::MT_WRITE_COMBINING : emt_pkg::MT_UNCACHEABLE;
			end
			emt_pkg::MT_WRITE_COMBINING: begin
				if ((entry_i == emt_pkg::MT_WEAK_UNCACHEABLE) ||
					(entry_i == emt_pkg::MT_WRITE_COMBINING) ||
					(entry_i == emt_pkg::MT_WRITE_BACK)) begin
					eff_o = emt_pkg::MT_WRITE_COMBINING;
				end else begin
					from_page_o = 1'b1;
				end
			end
			emt_pkg::MT_WRITE_THROUGH: begin
				if (entry_i == emt_pkg::MT_WRITE_COMBINING || entry_i == emt_pkg::MT_WRITE_PROTECTED)
					eff_o = entry_i;
				else if (entry_i == emt_pkg::MT_WRITE_THROUGH || entry_i == emt_pkg::MT_WRITE_BACK)
					eff_o = emt_pkg::MT_WRITE_THROUGH;
				else
					from_page_o = 1'b1;
			end
			emt_pkg::MT_WRITE_PROTECTED: begin
				if (entry_i == emt_pkg::MT_UNCACHEABLE)
					from_page_o = 1'b1;
				else if (entry_i == emt_pkg::MT_WEAK_UNCACHEABLE || entry_i == emt_pkg::MT_WRITE_COMBINING)
					eff_o = emt_pkg::MT_WRITE_COMBINING;
				else if (entry_i == emt_pkg::MT_WRITE_THROUGH)
					eff_o = emt_pkg::MT_WRITE_THROUGH;
				else
					eff_o = emt_pkg::MT_WRITE_PROTECTED;
			end
			emt_pkg::MT_WRITE_BACK: begin
				if (entry_i == emt_pkg::MT_WEAK_UNCACHEABLE || entry_i == emt_pkg::MT_UNCACHEABLE)
					from_page_o = 1'b1;
				else
					eff_o = entry_i;
			end
			default: begin
				eff_o       = emt_pkg::MT_UNCACHEABLE;
				from_page_o = 1'b0;
			end
		endcase
	end

endmodule : emt_table_map

/* verification/emt_resolver_asserts.sv */
// port-level assertions for the effective memory type resolver
`timescale 1ns/1ps
module emt_resolver_asserts (
	input wire logic       CLK_SYS_I,    // clock
	input wire logic       RST_I,        // reset
	input wire logic       PSEL_I,       // apb select
	input wire logic       PENABLE_I,    // apb access
	input wire logic       PSLVERR_O,    // apb error
	input wire logic       REQ_VALID_I,  // request
	input wire logic [2:0] REQ_RANGE_I,  // range type
	input wire logic       REQ_PAT_I,    // table bit
	input wire logic       REQ_WRITE_I,  // write
	input wire logic       REQ_CONT_I,   // second page
	input wire logic       RES_VALID_O,  // result pulse
	input wire logic [2:0] RES_TYPE_O,   // result type
	input wire logic       RES_CHECK_O,  // cache lookup
	input wire logic       RES_FILL_O,   // fill allowed
	input wire logic       RES_STRICT_O, // strict order
	input wire logic       RES_SPLIT_O,  // split write
	input wire logic       NO_FILL_O     // cache-disable
);
	// ==========================================================================
	// assertions
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	a_res_one_later: assert property (REQ_VALID_I |=> RES_VALID_O)
		else $error("result pulse missing");
	a_no_spurious_res: assert property (!REQ_VALID_I |=> !RES_VALID_O)
		else $error("result pulse without request");
	a_range_uc_nocheck: assert property (REQ_VALID_I && REQ_RANGE_I == 3'h0 && !REQ_PAT_I
		|=> RES_TYPE_O == emt_pkg::MT_UNCACHEABLE && !RES_CHECK_O)
		else $error("range uncacheable not kept");
	a_strict_only_uc: assert property (RES_VALID_O |->
		RES_STRICT_O == (RES_TYPE_O == emt_pkg::MT_UNCACHEABLE))
		else $error("strict flag disagrees with type");
	a_fill_types: assert property (RES_FILL_O |-> emt_pkg::mt_fills(RES_TYPE_O))
		else $error("fill on non-caching type");
	a_no_fill_mode: assert property (REQ_VALID_I && NO_FILL_O |=> !RES_FILL_O)
		else $error("fill while cache-disable set");
	a_split_cause: assert property (RES_SPLIT_O |->
		RES_VALID_O && $past(REQ_WRITE_I) && $past(REQ_CONT_I))
		else $error("split without crossing write");
	a_slverr_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
		else $error("error outside access phase");
	c_split: cover property (RES_SPLIT_O);
	c_wc: cover property (RES_VALID_O && RES_TYPE_O == emt_pkg::MT_WRITE_COMBINING);
	c_err: cover property (PSLVERR_O);
endmodule : emt_resolver_asserts

bind emt_resolver emt_resolver_asserts u_chk (.*);

/* verification/emt_cache_model.sv */
// cache controller model: answers a flush order with a done pulse
`timescale 1ns/1ps
module emt_cache_model (
	input  wire logic clk_i,   // clock
	input  wire logic rst_i,   // reset
	input  wire logic flush_i, // flush order, pulse
	output logic      done_o   // flush finished, pulse
);
	logic [3:0] cnt_q;
	// a flush takes several cycles, so done never lands on the ordering edge
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= 4'h0;
		else if (flush_i)
			cnt_q <= 4'h5;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign done_o = (cnt_q == 4'h1);
endmodule : emt_cache_model

/* verification/tb_top.sv */
// self-checking testbench for the effective memory type resolver
`timescale 1ns/1ps
module tb_top;
	// ==========================================================================
	// signals carry the port names so the instance connects by name
	logic        CLK_SYS_I = 1'h0, RST_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0;
	logic        PWRITE_I = 1'h0, REQ_VALID_I = 1'h0, REQ_PCD_I = 1'h0, REQ_PWT_I = 1'h0;
	logic        REQ_PAT_I = 1'h0, REQ_WRITE_I = 1'h0, REQ_CONT_I = 1'h0, flush_req = 1'h0;
	logic [11:0] PADDR_I = 12'h0;
	logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
	logic [3:0]  PSTRB_I = 4'hf;
	logic [2:0]  REQ_RANGE_I = 3'h0, RES_TYPE_O;
	logic        PREADY_O, PSLVERR_O, RES_VALID_O, RES_CHECK_O, RES_FILL_O, err;
	logic        RES_STRICT_O, RES_SPLIT_O, NO_FILL_O, NO_WB_O, RANGE_OFF_O, FLUSH_DONE_I;
	int          bad_count = 0, total_checks = 0;
	localparam logic [2:0] UC = emt_pkg::MT_UNCACHEABLE, WC = emt_pkg::MT_WRITE_COMBINING;
	localparam logic [2:0] WT = emt_pkg::MT_WRITE_THROUGH, WP = emt_pkg::MT_WRITE_PROTECTED;
	localparam logic [2:0] WB = emt_pkg::MT_WRITE_BACK, UM = emt_pkg::MT_WEAK_UNCACHEABLE;
	localparam logic [2:0] RNG [5] = '{UC, WC, WT, WP, WB};
	localparam logic [2:0] ENT [6] = '{UC, WC, WT, WP, WB, UM};

	emt_resolver dut (.*);
	emt_cache_model u_cache (.clk_i(CLK_SYS_I), .rst_i(RST_I), .flush_i(flush_req),
		.done_o(FLUSH_DONE_I));
	always #10 CLK_SYS_I = ~CLK_SYS_I;

	// ==========================================================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_SYS_I);
		PSEL_I <= 1'h1;
		PWRITE_I <= wr;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_SYS_I);
		PENABLE_I <= 1'h1;
		// no local limit: only the watchdog ends a wait for ready
		do begin
			@(posedge CLK_SYS_I);
		end while (PREADY_O !== 1'h1);
		rd = PRDATA_O;
		err = PSLVERR_O;
		PSEL_I <= 1'h0;
		PENABLE_I <= 1'h0;
		// let this edge's register update settle before callers look at outputs
		#1;
	endtask : apb
	// f = {pcd, pwt, table bit, write, second page}
	task automatic req(input logic [2:0] r, input logic [4:0] f);
		@(posedge CLK_SYS_I);
		REQ_VALID_I <= 1'h1;
		REQ_RANGE_I <= r;
		{REQ_PCD_I, REQ_PWT_I, REQ_PAT_I, REQ_WRITE_I, REQ_CONT_I} <= f;
		@(posedge CLK_SYS_I);
		REQ_VALID_I <= 1'h0;
		#1;
		check(RES_VALID_O, 1'h1);
	endtask : req
	task automatic flush;
		@(posedge CLK_SYS_I);
		flush_req <= 1'h1;
		@(posedge CLK_SYS_I);
		flush_req <= 1'h0;
		repeat (8) @(posedge CLK_SYS_I);
	endtask : flush
	function automatic logic [2:0] leg(input logic [2:0] r, input logic page_cache_disable, input logic page_write_through);
		if (!page_cache_disable && !page_write_through)
			return r;
		if (!page_cache_disable)
			return (r == WB) ? WT : r;
		if (!page_write_through && (r == WC || r == WP))
			return WC;
		return UC;
	endfunction : leg
	function automatic logic [2:0] tab(input logic [2:0] r, input logic [2:0] e);
		case (r)
			UC: return (e == WC) ? WC : UC;
			WC: return (e == UM || e == WC || e == WB) ? WC : UC;
			WT: return (e == UC || e == UM) ? UC : (e == WB) ? WT : e;
			WP: return (e == UC) ? UC : (e == UM || e == WC) ? WC : (e == WB) ? WP : e;
			default: return (e == UM) ? UC : e;
		endcase
	endfunction : tab

	// ==========================================================================
	// scenarios
	task automatic t_reset;
		apb(1'h0, emt_pkg::ADDR_CTRL, 32'h0);
		check(rd, emt_pkg::CTRL_RESET);
		check({NO_FILL_O, NO_WB_O}, 2'h3);
		apb(1'h0, emt_pkg::ADDR_ATTR, 32'h0);
		check(rd, emt_pkg::ATTR_RESET);
		apb(1'h0, 12'h010, 32'h0);
		check(err, 1'h1);
		check(rd, 32'h0);
		apb(1'h1, emt_pkg::ADDR_STATUS, 32'h0);
		check(err, 1'h1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_legacy;
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h1);
		for (int i = 0; i < 5; i++)
			for (int j = 0; j < 4; j++) begin
				req(RNG[i], {j[1:0], 3'h0});
				check(RES_TYPE_O, leg(RNG[i], j[1], j[0]));
				check(RES_CHECK_O, RNG[i] != UC);
			end
		$display("test legacy done");
	endtask : t_legacy
	task automatic t_table;
		logic [2:0] e;
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h3);
		for (int k = 0; k < 6; k++) begin
			apb(1'h1, emt_pkg::ADDR_ATTR, 32'(ENT[k]) << (3 * (4 + k % 4)));
			for (int i = 0; i < 5; i++) begin
				req(RNG[i], {k[1:0], 3'h4});
				e = tab(RNG[i], ENT[k]);
				check(RES_TYPE_O, e);
				check(RES_CHECK_O, !(RNG[i] == UC && e == UC));
			end
		end
		req(WB, 5'h10);
		check(RES_TYPE_O, UC);
		$display("test table done");
	endtask : t_table
	task automatic t_modes;
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h2000_0001);
		req(WB, 5'h18);
		check(RES_TYPE_O, WB);
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h0);
		req(WB, 5'h10);
		check(RES_TYPE_O, WB);
		$display("test modes done");
	endtask : t_modes
	task automatic t_seq;
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h4000_0001);
		check({NO_FILL_O, NO_WB_O}, 2'h2);
		req(WB, 5'h10);
		check({RES_TYPE_O, RES_CHECK_O, RES_FILL_O, RES_STRICT_O}, {WB, 3'h4});
		flush;
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h4000_0005);
		check(RANGE_OFF_O, 1'h1);
		req(WB, 5'h00);
		check({RES_TYPE_O, RES_STRICT_O}, {UC, 1'h1});
		flush;
		apb(1'h0, emt_pkg::ADDR_STATUS, 32'h0);
		check(rd[11:8], 4'hf);
		apb(1'h1, emt_pkg::ADDR_CTRL, 32'h1);
		apb(1'h0, emt_pkg::ADDR_STATUS, 32'h0);
		check(rd[11:8], 4'h0);
		$display("test sequence done");
	endtask : t_seq
	task automatic t_split;
		req(WB, 5'h02);
		check(RES_SPLIT_O, 1'h0);
		check({RES_FILL_O, RES_STRICT_O}, 2'h2);
		req(WB, 5'h0b);
		check({RES_TYPE_O, RES_SPLIT_O}, {WT, 1'h1});
		req(WB, 5'h0b);
		check(RES_SPLIT_O, 1'h0);
		req(WB, 5'h01);
		check(RES_SPLIT_O, 1'h0);
		apb(1'h0, emt_pkg::ADDR_SPLIT, 32'h0);
		check(rd, 32'h1);
		apb(1'h1, emt_pkg::ADDR_SPLIT, 32'h5);
		apb(1'h0, emt_pkg::ADDR_SPLIT, 32'h0);
		check(rd, 32'h0);
		$display("test split done");
	endtask : t_split
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	initial begin
		repeat (12) @(posedge CLK_SYS_I);
		RST_I <= 1'h0;
		t_reset;
		t_legacy;
		t_table;
		t_modes;
		t_seq;
		t_split;
		results;
	end
	initial begin
		#200000;
		bad_count++;
		results;
	end
endmodule : tb_top
